// ### rtl/brtc_defines.vh
// Constants for the byte-wide calendar clock with battery-backed memory.
// Assumes inclusion by brtc_top.v only.
`ifndef BRTC_DEFINES_VH
`define BRTC_DEFINES_VH
`define BRTC_ADDR_W 15
`define BRTC_DATA_W 8
`define BRTC_MEM_DEPTH 32768
`define BRTC_REG_BASE 15'h7ff8
`define BRTC_IDX_CENT 3'h0
`define BRTC_IDX_SEC 3'h1
`define BRTC_IDX_MIN 3'h2
`define BRTC_IDX_HOUR 3'h3
`define BRTC_IDX_DAY 3'h4
`define BRTC_IDX_DATE 3'h5
`define BRTC_IDX_MONTH 3'h6
`define BRTC_IDX_YEAR 3'h7
`define BRTC_BIT_WRITE 7
`define BRTC_BIT_READ 6
`define BRTC_CLK_HZ 25000000
`define BRTC_RESET_NS 40000
`define BRTC_SEC_MAX 8'h59
`define BRTC_HOUR_MAX 8'h23
`define BRTC_DAY_MAX 8'h07
`define BRTC_MONTH_MAX 8'h12
`define BRTC_YEAR_MAX 8'h99
`define BRTC_CENT_MAX 8'h39
`define BRTC_ONE 8'h01
`define BRTC_ZERO 8'h00
`endif

// ### rtl/brtc_top.v
// Byte-wide calendar clock with 32k x 8 battery-backed memory.
// Assumes an async SRAM-style host bus, synchronised here on clk_sys, and
// a supply monitor level input. Reset pin is open drain, pulled up outside.
`include "brtc_defines.vh"

// Function
// - 32k x 8 memory, clock in top eight
// - Clock registers use plain memory cycles
// - BCD calendar fields, 24-hour hours
// - Month lengths and leap years to 2100
// - Host sees buffered copy of counters
// - Counters keep running during host access
// - Supply fault deselects port entirely
// - Chip, output, write enables active low
// - Open-drain active-low reset output
// - Read bit freezes copy, refresh after clear
// - Write bit halts; clear loads counters
module brtc_top #(
	parameter TICK_DIV = `BRTC_CLK_HZ,
	parameter RESET_CYCLES = `BRTC_RESET_NS / 40
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Host bus
	input wire [`BRTC_ADDR_W-1:0] addrBus,
	input wire chipEn_n,
	input wire outEn_n,
	input wire writeEn_n,
	input wire [`BRTC_DATA_W-1:0] dataBusPinsIn,
	output reg [`BRTC_DATA_W-1:0] dataBusPinsOut,
	output wire dataBusPinsOe,
	// Supply monitor
	input wire supplyFail,
	// Open-drain reset
	input wire resetOutIn,
	output wire resetOut_n,
	output wire resetOutOe
);
	function [7:0] bcdInc;
		input [7:0] v;
		begin
			if (v[3:0] == 4'h9)
				bcdInc = {v[7:4] + 4'h1, 4'h0};
			else
				bcdInc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction

	function [7:0] monthDays;
		input [7:0] m;
		input [7:0] y;
		input [7:0] c;
		reg leap;
		begin
			// BCD year divisible by four: even tens with 0/4/8, odd tens with 2/6
			leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && y[3:2] != 2'b11) :
				(y[3:0] == 4'h2 || y[3:0] == 4'h6);
			// Century years: only a multiple of 400 leaps (2000 yes, 2100 no)
			if (y == 8'h00)
				leap = (c[4] == 1'b0) ? (c[1:0] == 2'b00 && c[3:2] != 2'b11) :
					(c[3:0] == 4'h2 || c[3:0] == 4'h6);
			case (m)
				8'h02: monthDays = leap ? 8'h29 : 8'h28;
				8'h04, 8'h06, 8'h09, 8'h11: monthDays = 8'h30;
				default: monthDays = 8'h31;
			endcase
		end
	endfunction

	// Three-stage synchronisers on every pin input
	reg [2:0] ceSync, oeSync, weSync, pfSync, roSync;
	reg [`BRTC_ADDR_W-1:0] aS1, aS2, aS3;
	reg [7:0] dS1, dS2, dS3;
	reg ce, oe, we, pf;
	reg [`BRTC_ADDR_W-1:0] addr;
	reg [7:0] wdata;
	always @(posedge clk_sys)
	begin
		ceSync <= {ceSync[1:0], ~chipEn_n};
		oeSync <= {oeSync[1:0], ~outEn_n};
		weSync <= {weSync[1:0], ~writeEn_n};
		pfSync <= {pfSync[1:0], supplyFail};
		roSync <= {roSync[1:0], resetOutIn};
		aS1 <= addrBus;
		aS2 <= aS1;
		aS3 <= aS2;
		dS1 <= dataBusPinsIn;
		dS2 <= dS1;
		dS3 <= dS2;
		if (!rst_n)
		begin
			ce <= 1'b0;
			oe <= 1'b0;
			we <= 1'b0;
			pf <= 1'b1;
		end
		else
		begin
			if (ceSync[1] == ceSync[2]) ce <= ceSync[2];
			if (oeSync[1] == oeSync[2]) oe <= oeSync[2];
			if (weSync[1] == weSync[2]) we <= weSync[2];
			if (pfSync[1] == pfSync[2]) pf <= pfSync[2];
		end
		if (aS2 == aS3) addr <= aS3;
		if (dS2 == dS3) wdata <= dS3;
	end

	// Port qualified by supply state
	wire sel = ce & ~pf;
	wire isClk = (addr >= `BRTC_REG_BASE);
	wire [2:0] idx = addr[2:0];
	reg weDly;
	wire wrStrobe = sel & we & ~weDly;
	always @(posedge clk_sys)
		weDly <= !rst_n ? 1'b0 : (sel & we);

	// Plain memory; top eight words shadowed by clock logic
	reg [7:0] mem [0:`BRTC_MEM_DEPTH-1];
	always @(posedge clk_sys)
		if (wrStrobe && !isClk)
			mem[addr] <= wdata;

	// Internal counters and the host-visible copy
	reg [7:0] cnt [0:7];
	reg [7:0] ext [0:7];
	reg wBit, rBit;
	reg [31:0] divCnt;
	reg [31:0] holdCnt;
	wire tick = (divCnt == TICK_DIV - 1);
	wire rolSec = cnt[`BRTC_IDX_SEC][6:0] == `BRTC_SEC_MAX;
	wire rolMin = cnt[`BRTC_IDX_MIN][6:0] == `BRTC_SEC_MAX;
	wire rolHour = cnt[`BRTC_IDX_HOUR][5:0] == `BRTC_HOUR_MAX;
	wire rolDate = cnt[`BRTC_IDX_DATE][5:0] ==
		monthDays(cnt[`BRTC_IDX_MONTH], cnt[`BRTC_IDX_YEAR], cnt[`BRTC_IDX_CENT]);
	wire rolMonth = cnt[`BRTC_IDX_MONTH][4:0] == `BRTC_MONTH_MAX;
	wire rolYear = cnt[`BRTC_IDX_YEAR] == `BRTC_YEAR_MAX;
	// Falling write bit: counter load beats a tick in the same cycle
	wire cntLoad = wrStrobe && isClk && (idx == `BRTC_IDX_CENT) && wBit &&
		!wdata[`BRTC_BIT_WRITE];
	integer i;
	always @(posedge clk_sys)
	begin
		if (!rst_n)
		begin
			divCnt <= 32'h0;
			wBit <= 1'b0;
			rBit <= 1'b0;
			for (i = 0; i < 8; i = i + 1)
			begin
				cnt[i] <= `BRTC_ZERO;
				ext[i] <= `BRTC_ZERO;
			end
			cnt[`BRTC_IDX_DAY] <= `BRTC_ONE;
			cnt[`BRTC_IDX_DATE] <= `BRTC_ONE;
			cnt[`BRTC_IDX_MONTH] <= `BRTC_ONE;
			ext[`BRTC_IDX_DAY] <= `BRTC_ONE;
			ext[`BRTC_IDX_DATE] <= `BRTC_ONE;
			ext[`BRTC_IDX_MONTH] <= `BRTC_ONE;
		end
		else
		begin
			// Timebase runs regardless of halt bits; only a falling write bit restarts it
			divCnt <= tick ? 32'h0 : divCnt + 32'h1;
			if (wrStrobe && isClk && idx == `BRTC_IDX_CENT)
			begin
				wBit <= wdata[`BRTC_BIT_WRITE];
				rBit <= wdata[`BRTC_BIT_READ];
				ext[`BRTC_IDX_CENT] <= {2'b00, wdata[5:0]};
				// Falling write bit loads the counters from the copy
				if (wBit && !wdata[`BRTC_BIT_WRITE])
				begin
					for (i = 1; i < 8; i = i + 1)
						cnt[i] <= ext[i];
					cnt[`BRTC_IDX_CENT] <= {2'b00, wdata[5:0]};
					divCnt <= 32'h0;
				end
			end
			else if (wrStrobe && isClk && wBit)
				ext[idx] <= wdata;
			// Only a counter load may swallow a tick; other bus writes must not, or time would be lost
			if (tick && !cntLoad)
			begin
				cnt[`BRTC_IDX_SEC] <= rolSec ? `BRTC_ZERO : bcdInc(cnt[`BRTC_IDX_SEC]);
				if (rolSec)
				begin
					cnt[`BRTC_IDX_MIN] <= rolMin ? `BRTC_ZERO : bcdInc(cnt[`BRTC_IDX_MIN]);
					if (rolMin)
					begin
						cnt[`BRTC_IDX_HOUR] <= rolHour ? `BRTC_ZERO :
							bcdInc(cnt[`BRTC_IDX_HOUR]);
						if (rolHour)
						begin
							cnt[`BRTC_IDX_DAY] <= (cnt[`BRTC_IDX_DAY][2:0] == 3'h7) ?
								`BRTC_ONE : bcdInc(cnt[`BRTC_IDX_DAY]);
							cnt[`BRTC_IDX_DATE] <= rolDate ? `BRTC_ONE :
								bcdInc(cnt[`BRTC_IDX_DATE]);
							if (rolDate)
							begin
								cnt[`BRTC_IDX_MONTH] <= rolMonth ? `BRTC_ONE :
									bcdInc(cnt[`BRTC_IDX_MONTH]);
								if (rolMonth)
								begin
									cnt[`BRTC_IDX_YEAR] <= rolYear ? `BRTC_ZERO :
										bcdInc(cnt[`BRTC_IDX_YEAR]);
									if (rolYear)
										cnt[`BRTC_IDX_CENT] <=
											(cnt[`BRTC_IDX_CENT] == `BRTC_CENT_MAX) ?
											`BRTC_ZERO : bcdInc(cnt[`BRTC_IDX_CENT]);
								end
							end
						end
					end
				end
			end
			// Copy refreshes every cycle unless a halt bit is set or the host is writing a clock register
			if (!wBit && !rBit && !(wrStrobe && isClk))
				for (i = 0; i < 8; i = i + 1)
					ext[i] <= cnt[i];
		end
	end

	// Read path; data comes from a flop, enable follows the strobes
	always @(posedge clk_sys)
	begin
		if (!rst_n)
			dataBusPinsOut <= `BRTC_ZERO;
		else if (isClk && idx == `BRTC_IDX_CENT)
			dataBusPinsOut <= {wBit, rBit, ext[idx][5:0]};
		else if (isClk)
			dataBusPinsOut <= ext[idx];
		else
			dataBusPinsOut <= mem[addr];
	end
	assign dataBusPinsOe = sel & oe & ~we;

	// Reset output held low during supply fault and a short time after
	reg [31:0] rstCnt;
	always @(posedge clk_sys)
		if (!rst_n || pf)
			rstCnt <= 32'h0;
		else if (rstCnt != RESET_CYCLES)
			rstCnt <= rstCnt + 32'h1;
	wire rstAssert = pf | (rstCnt != RESET_CYCLES);
	assign resetOut_n = 1'b0;
	assign resetOutOe = rstAssert;
endmodule

// ### testbench/brtc_asserts.sv
// Port checker for the calendar clock with battery-backed memory.
// Assumes binding to brtc_top; strobes and supply flag settle in five clocks.
module brtc_asserts #(
	parameter TICK_DIV = 25000000,
	parameter RESET_CYCLES = 1000
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst_n,
	// Host bus
	input wire [14:0] addrBus,
	input wire chipEn_n,
	input wire outEn_n,
	input wire writeEn_n,
	input wire [7:0] dataBusPinsIn,
	input wire [7:0] dataBusPinsOut,
	input wire dataBusPinsOe,
	// Supply and reset pin
	input wire supplyFail,
	input wire resetOutIn,
	input wire resetOut_n,
	input wire resetOutOe
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence readHeld;
		(!chipEn_n && !outEn_n && writeEn_n && !supplyFail && !resetOutOe)[*5];
	endsequence
	// Cycles since reset and supply both became good; sync delay costs a few
	logic [31:0] quietRun;
	always @(posedge clk_sys)
		if (!rst_n || supplyFail)
			quietRun <= 32'h0;
		else
			quietRun <= quietRun + 32'h1;
	a_read_drives_pins: assert property (readHeld |-> dataBusPinsOe)
		else $error("pins idle during read");
	a_deselect_idle: assert property (chipEn_n[*5] |-> !dataBusPinsOe)
		else $error("pins driven while deselected");
	a_write_no_drive: assert property ((!writeEn_n)[*5] |-> !dataBusPinsOe)
		else $error("pins driven during write");
	a_fail_deselects: assert property (supplyFail[*5] |-> !dataBusPinsOe)
		else $error("pins driven with supply out");
	a_oe_release: assert property ($rose(chipEn_n) |-> ##[1:5] !dataBusPinsOe)
		else $error("pins not released");
	a_reset_pulls_low: assert property (!resetOut_n)
		else $error("reset pin driven high");
	a_reset_stretch: assert property ($rose(rst_n) |-> resetOutOe[*8])
		else $error("reset pulse too short");
	a_reset_release: assert property ((quietRun >= RESET_CYCLES + 6) |-> !resetOutOe)
		else $error("reset pulse never ends");
	a_reset_held: assert property ((quietRun != 32'h0 && quietRun <= RESET_CYCLES) |->
		resetOutOe)
		else $error("reset pulse ended early");
	a_fail_resets: assert property (supplyFail[*5] |-> resetOutOe)
		else $error("reset not pulled on supply fault");
endmodule
bind brtc_top brtc_asserts #(.TICK_DIV(TICK_DIV), .RESET_CYCLES(RESET_CYCLES)) chk (
	.clk_sys(clk_sys), .rst_n(rst_n), .addrBus(addrBus), .chipEn_n(chipEn_n),
	.outEn_n(outEn_n), .writeEn_n(writeEn_n), .dataBusPinsIn(dataBusPinsIn),
	.dataBusPinsOut(dataBusPinsOut), .dataBusPinsOe(dataBusPinsOe), .supplyFail(supplyFail),
	.resetOutIn(resetOutIn), .resetOut_n(resetOut_n), .resetOutOe(resetOutOe));

// ### testbench/brtc_host_model.sv
// Host processor on the asynchronous byte-wide memory bus.
// Assumes its tasks are called one at a time from the bench.
module brtc_host_model
(
	// Clock
	input wire clk_sys,
	// Bus to the device
	output logic [14:0] addrBus,
	output logic chipEn_n,
	output logic outEn_n,
	output logic writeEn_n,
	output wire [7:0] dataBusPinsIn,
	input wire [7:0] dataBusPinsOut,
	input wire dataBusPinsOe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] wrData = 8'h00;
	logic drive = 1'b0;
	// Released pins show the inverse, so a stale value cannot pass
	assign dataBusPinsIn = dataBusPinsOe ? dataBusPinsOut : (drive ? wrData : ~wrData);
	initial
	begin
		addrBus = 15'h0000;
		chipEn_n = 1'b1;
		outEn_n = 1'b1;
		writeEn_n = 1'b1;
	end
	task automatic wr(input logic [14:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		addrBus <= a;
		wrData <= d;
		drive <= 1'b1;
		chipEn_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		writeEn_n <= 1'b0;
		repeat (5) @(posedge clk_sys);
		writeEn_n <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chipEn_n <= 1'b1;
		drive <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask
	task automatic rd(input logic [14:0] a, output logic [7:0] d, output logic oe);
		@(posedge clk_sys);
		addrBus <= a;
		chipEn_n <= 1'b0;
		outEn_n <= 1'b0;
		repeat (8) @(posedge clk_sys);
		d = dataBusPinsOut;
		oe = dataBusPinsOe;
		chipEn_n <= 1'b1;
		outEn_n <= 1'b1;
		repeat (5) @(posedge clk_sys);
	endtask
endmodule

// ### testbench/tb.sv
// Self-checking bench for the calendar clock with memory.
// Assumes a pull-up on the reset line; tick shortened to 50 clocks.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clkSys;
	logic rst_n;
	logic supplyFail;
	logic [7:0] d;
	logic o;
	int nErrors = 0;
	int cmpCount = 0;
	wire [14:0] addrBus;
	wire chipEn_n, outEn_n, writeEn_n, dataBusPinsOe, resetOut_n, resetOutOe;
	wire [7:0] dataBusPinsIn, dataBusPinsOut;
	wire resetLine = resetOutOe ? resetOut_n : 1'b1;
	logic [7:0] setV [1:7] = '{8'h59, 8'h59, 8'h23, 8'h07, 8'h28, 8'h02, 8'h00};
	logic [7:0] expV [1:7] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h29, 8'h02, 8'h00};
	brtc_top #(.TICK_DIV(50), .RESET_CYCLES(20)) uut (.clk_sys(clkSys), .rst_n(rst_n),
		.addrBus(addrBus), .chipEn_n(chipEn_n), .outEn_n(outEn_n), .writeEn_n(writeEn_n),
		.dataBusPinsIn(dataBusPinsIn), .dataBusPinsOut(dataBusPinsOut),
		.dataBusPinsOe(dataBusPinsOe), .supplyFail(supplyFail), .resetOutIn(resetLine),
		.resetOut_n(resetOut_n), .resetOutOe(resetOutOe));
	brtc_host_model host (.clk_sys(clkSys), .addrBus(addrBus), .chipEn_n(chipEn_n),
		.outEn_n(outEn_n), .writeEn_n(writeEn_n), .dataBusPinsIn(dataBusPinsIn),
		.dataBusPinsOut(dataBusPinsOut), .dataBusPinsOe(dataBusPinsOe));
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		cmpCount++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finalReport();
		$display("mismatches %0d compares %0d", nErrors, cmpCount);
		if (nErrors == 0 && cmpCount > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic waitReady();
		for (int i = 0; i < 200 && resetOutOe !== 1'b0; i++)
			@(posedge clkSys);
		if (resetOutOe !== 1'b0)
		begin
			nErrors++;
			finalReport();
		end
	endtask
	task automatic tRam();
		host.wr(15'h0000, 8'ha5);
		host.wr(15'h7ff7, 8'h5a);
		host.rd(15'h0000, d, o);
		check(d, 8'ha5);
		check({7'h00, o}, 8'h01);
		host.rd(15'h7ff7, d, o);
		check(d, 8'h5a);
	endtask
	task automatic tCalendar();
		logic [7:0] frozen;
		host.wr(15'h7ff8, 8'h80);
		for (int i = 1; i <= 7; i++)
			host.wr(15'h7ff8 + 15'(i), setV[i]);
		host.wr(15'h7ff8, 8'h20);
		repeat (45) @(posedge clkSys);
		host.wr(15'h7ff8, 8'h60);
		for (int i = 1; i <= 7; i++)
		begin
			host.rd(15'h7ff8 + 15'(i), d, o);
			check(d, expV[i]);
		end
		host.rd(15'h7ff8, d, o);
		check(d & 8'h3f, 8'h20);
		check(d, 8'h60);
		host.rd(15'h7ff9, frozen, o);
		check(frozen, 8'h00);
		host.wr(15'h7ff8, 8'h20);
		host.rd(15'h7ff9, d, o);
		check({7'h00, d != frozen}, 8'h01);
	endtask
	// Year 2100 is not a leap year: Feb 28 rolls to Mar 01
	task automatic tCentury();
		host.wr(15'h7ff8, 8'h80);
		for (int i = 1; i <= 7; i++)
			host.wr(15'h7ff8 + 15'(i), setV[i]);
		host.wr(15'h7ff8, 8'h21);
		repeat (45) @(posedge clkSys);
		host.wr(15'h7ff8, 8'h61);
		host.rd(15'h7ffd, d, o);
		check(d, 8'h01);
		host.rd(15'h7ffe, d, o);
		check(d, 8'h03);
		host.wr(15'h7ff8, 8'h21);
	endtask
	task automatic tFail();
		host.wr(15'h0010, 8'h33);
		@(posedge clkSys) supplyFail <= 1'b1;
		repeat (6) @(posedge clkSys);
		host.wr(15'h0010, 8'hcc);
		host.rd(15'h0010, d, o);
		check({7'h00, o}, 8'h00);
		check({7'h00, resetLine}, 8'h00);
		@(posedge clkSys) supplyFail <= 1'b0;
		repeat (6) @(posedge clkSys);
		waitReady();
		host.rd(15'h0010, d, o);
		check(d, 8'h33);
	endtask
	initial
	begin
		clkSys = 1'b0;
		forever #20 clkSys = ~clkSys;
	end
	initial
	begin
		rst_n = 1'b0;
		supplyFail = 1'b0;
		repeat (4) @(posedge clkSys);
		rst_n <= 1'b1;
		waitReady();
		tRam();
		tCalendar();
		tCentury();
		tFail();
		finalReport();
	end
endmodule
